//--- verilog/serial_port_defs.vh
// Constants shared by the serial command port and its register bank
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH

// Frame layout
`define FRAME_BITS 5'd20
`define FRAME_CNT_W 5
`define CMD_MSB 19
`define CMD_LSB 16
`define ADDR_MSB 15
`define ADDR_LSB 8
`define DATA_MSB 7
`define DATA_LSB 0

// Command codes
`define IDLE_CMD 4'h0
`define WRITE_CMD 4'h1
`define READ_CMD 4'h2
`define MASK_SET_CMD 4'h3
`define MASK_CLEAR_CMD 4'h4

// Register offsets
`define OFS_POWER_STATE 8'h04
`define OFS_UNLOCK_KEY 8'h05
`define OFS_LANE_SELECT 8'h0D
`define OFS_NUMBER_FORMAT 8'h11
`define OFS_REF_SOURCE 8'h20
`define OFS_TRIM_A_LOW 8'h24
`define OFS_TRIM_A_HIGH 8'h25
`define OFS_TRIM_B_LOW 8'h26
`define OFS_TRIM_B_HIGH 8'h27
`define OFS_INPUT_SETUP 8'h28

// Writable bit masks, reserved bits stay zero
`define MSK_POWER_STATE 8'h06
`define MSK_UNLOCK_KEY 8'h0F
`define MSK_LANE_SELECT 8'h01
`define MSK_NUMBER_FORMAT 8'h01
`define MSK_REF_SOURCE 8'h01
`define MSK_TRIM_LOW 8'hFF
`define MSK_TRIM_HIGH 8'h01
`define MSK_INPUT_SETUP 8'h03

// Reset value of every register
`define REG_RESET 8'h00

// Field positions
`define BIT_STANDBY 2
`define BIT_FULL_PD 1
`define BIT_LANE_MODE 0
`define BIT_FORMAT 0
`define BIT_INT_REF 0
`define KEY_MSB 3
`define UNLOCK_VALUE 4'h9

// Power-up settling times and core clock rate
`define CORE_CLK_MHZ 10
`define WAKE_EXT_REF_US 1000
`define WAKE_INT_REF_US 3000
`define WAKE_STANDBY_US 10

`endif

//--- verilog/config_reg_bank.v
// Configuration register bank with registered read port
`timescale 1ns/10ps
`include "serial_port_defs.vh"

module config_reg_bank (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Write port
    input wire wr_en,
    input wire [7:0] wr_addr,
    input wire [7:0] wr_data,
    // Read port
    input wire [7:0] rd_addr,
    output reg [7:0] rd_data_r,
    // Register contents
    output reg [7:0] power_state_r,
    output reg [7:0] unlock_key_r,
    output reg [7:0] lane_select_r,
    output reg [7:0] number_format_r,
    output reg [7:0] ref_source_r,
    output reg [7:0] trim_a_low_r,
    output reg [7:0] trim_a_high_r,
    output reg [7:0] trim_b_low_r,
    output reg [7:0] trim_b_high_r,
    output reg [7:0] input_setup_r
);

    ////////////////////////////////////////////////////////////////////////
    // Register writes, masked to implemented bits
    always @(posedge core_clk) begin
        if (srst) begin
            power_state_r <= `REG_RESET;
            unlock_key_r <= `REG_RESET;
            lane_select_r <= `REG_RESET;
            number_format_r <= `REG_RESET;
            ref_source_r <= `REG_RESET;
            trim_a_low_r <= `REG_RESET;
            trim_a_high_r <= `REG_RESET;
            trim_b_low_r <= `REG_RESET;
            trim_b_high_r <= `REG_RESET;
            input_setup_r <= `REG_RESET;
        end else if (wr_en) begin
            case (wr_addr)
                `OFS_POWER_STATE: power_state_r <= wr_data & `MSK_POWER_STATE;
                `OFS_UNLOCK_KEY: unlock_key_r <= wr_data & `MSK_UNLOCK_KEY;
                `OFS_LANE_SELECT: lane_select_r <= wr_data & `MSK_LANE_SELECT;
                `OFS_NUMBER_FORMAT: number_format_r <= wr_data & `MSK_NUMBER_FORMAT;
                `OFS_REF_SOURCE: ref_source_r <= wr_data & `MSK_REF_SOURCE;
                `OFS_TRIM_A_LOW: trim_a_low_r <= wr_data & `MSK_TRIM_LOW;
                `OFS_TRIM_A_HIGH: trim_a_high_r <= wr_data & `MSK_TRIM_HIGH;
                `OFS_TRIM_B_LOW: trim_b_low_r <= wr_data & `MSK_TRIM_LOW;
                `OFS_TRIM_B_HIGH: trim_b_high_r <= wr_data & `MSK_TRIM_HIGH;
                `OFS_INPUT_SETUP: input_setup_r <= wr_data & `MSK_INPUT_SETUP;
                // Unmapped offsets ignore writes
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered read, unmapped offsets read zero
    always @(posedge core_clk) begin
        if (srst) begin
            rd_data_r <= 8'h00;
        end else begin
            case (rd_addr)
                `OFS_POWER_STATE: rd_data_r <= power_state_r;
                `OFS_UNLOCK_KEY: rd_data_r <= unlock_key_r;
                `OFS_LANE_SELECT: rd_data_r <= lane_select_r;
                `OFS_NUMBER_FORMAT: rd_data_r <= number_format_r;
                `OFS_REF_SOURCE: rd_data_r <= ref_source_r;
                `OFS_TRIM_A_LOW: rd_data_r <= trim_a_low_r;
                `OFS_TRIM_A_HIGH: rd_data_r <= trim_a_high_r;
                `OFS_TRIM_B_LOW: rd_data_r <= trim_b_low_r;
                `OFS_TRIM_B_HIGH: rd_data_r <= trim_b_high_r;
                `OFS_INPUT_SETUP: rd_data_r <= input_setup_r;
                default: rd_data_r <= 8'h00;
            endcase
        end
    end

endmodule // config_reg_bank

//--- verilog/serial_command_port.v
// Serial command decoder, readback shifter and power control of the converter
`timescale 1ns/10ps
`include "serial_port_defs.vh"

////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

module serial_command_port #(
    parameter SHIFT_W = 32,
    parameter WAKE_EXT_CYC = `WAKE_EXT_REF_US * `CORE_CLK_MHZ,
    parameter WAKE_INT_CYC = `WAKE_INT_REF_US * `CORE_CLK_MHZ,
    parameter WAKE_STBY_CYC = `WAKE_STANDBY_US * `CORE_CLK_MHZ
) (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Serial pins from the host
    input wire cs_n,
    input wire sclk,
    input wire sdi,
    // Serial output lanes, two-signal form
    output reg serial_out_lane_a_r,
    output reg serial_out_lane_a_oe_r,
    output reg serial_out_lane_b_r,
    output reg serial_out_lane_b_oe_r,
    // Conversion results from the converter core
    input wire [15:0] conv_a_data,
    input wire [15:0] conv_b_data,
    // Power control toward the analog blocks
    output wire converters_standby,
    output wire full_powerdown_enable,
    output reg power_settled_r,
    // Configuration toward the analog blocks
    output wire output_lane_mode_bit,
    output wire twos_complement_fmt,
    output wire internal_ref_sel,
    output wire [7:0] ref_trim_a_low,
    output wire [7:0] ref_trim_a_high,
    output wire [7:0] ref_trim_b_low,
    output wire [7:0] ref_trim_b_high,
    output wire [7:0] input_setup
);

    // Decoder states
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_FETCH = 3'b010;
    localparam [2:0] ST_APPLY = 3'b100;

    // Settling counter width
    localparam CNT_W = 16;

    ////////////////////////////////////////////////////////////////////////////
    // New register value for a command
    function [7:0] apply_cmd;
        input [3:0] cmd;
        input [7:0] old_val;
        input [7:0] field;
        begin
            case (cmd)
                `WRITE_CMD: apply_cmd = field;
                `MASK_SET_CMD: apply_cmd = old_val | field;
                `MASK_CLEAR_CMD: apply_cmd = old_val & ~field;
                default: apply_cmd = old_val;
            endcase
        end
    endfunction

    // Whether a command modifies a register
    function is_modify;
        input [3:0] cmd;
        begin
            is_modify = (cmd == `WRITE_CMD) || (cmd == `MASK_SET_CMD) ||
                (cmd == `MASK_CLEAR_CMD);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers, first stage feeds only the second
    reg cs_n_s1_r; // First stage
    reg cs_n_s2_r; // Second stage
    reg cs_n_d_r; // Edge history
    reg sclk_s1_r;
    reg sclk_s2_r;
    reg sclk_d_r;
    reg sdi_s1_r;
    reg sdi_s2_r;

    // Two flip-flops on each pin, a third for edges
    always @(posedge core_clk) begin
        if (srst) begin
            cs_n_s1_r <= 1'b1;
            cs_n_s2_r <= 1'b1;
            cs_n_d_r <= 1'b1;
            sclk_s1_r <= 1'b1;
            sclk_s2_r <= 1'b1;
            sclk_d_r <= 1'b1;
            sdi_s1_r <= 1'b0;
            sdi_s2_r <= 1'b0;
        end else begin
            cs_n_s1_r <= cs_n;
            cs_n_s2_r <= cs_n_s1_r;
            cs_n_d_r <= cs_n_s2_r;
            sclk_s1_r <= sclk;
            sclk_s2_r <= sclk_s1_r;
            sclk_d_r <= sclk_s2_r;
            sdi_s1_r <= sdi;
            sdi_s2_r <= sdi_s1_r;
        end
    end

    // Edge events on the synchronised pins
    wire cs_rise = cs_n_s2_r & ~cs_n_d_r; // Frame end
    wire cs_fall = ~cs_n_s2_r & cs_n_d_r; // Frame start
    wire frame_on = ~cs_n_s2_r; // Frame in progress
    wire sclk_rise = sclk_s2_r & ~sclk_d_r;
    wire sclk_fall = ~sclk_s2_r & sclk_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // Input shifter and bit counter
    reg [19:0] frame_shift_r; // Last 20 bits seen
    reg [`FRAME_CNT_W-1:0] bit_cnt_r; // Saturates at frame length

    // Capture on serial clock rising edge
    always @(posedge core_clk) begin
        if (srst) begin
            frame_shift_r <= 20'h00000;
            bit_cnt_r <= {`FRAME_CNT_W{1'b0}};
        end else if (cs_fall) begin
            // New frame, restart count
            bit_cnt_r <= {`FRAME_CNT_W{1'b0}};
        end else if (frame_on && sclk_rise) begin
            frame_shift_r <= {frame_shift_r[18:0], sdi_s2_r};
            if (bit_cnt_r != `FRAME_BITS) begin
                bit_cnt_r <= bit_cnt_r + 1'b1;
            end
        end
    end

    // Command fields of the held frame
    wire [3:0] f_cmd = frame_shift_r[`CMD_MSB:`CMD_LSB];
    wire [7:0] f_addr = frame_shift_r[`ADDR_MSB:`ADDR_LSB];
    wire [7:0] f_data = frame_shift_r[`DATA_MSB:`DATA_LSB];
    wire frame_full = (bit_cnt_r == `FRAME_BITS);

    ////////////////////////////////////////////////////////////////////////////
    // Register bank and its connections
    reg wr_en_r; // One-cycle write strobe
    reg [7:0] wr_addr_r;
    reg [7:0] wr_data_r;
    wire [7:0] rd_data;
    wire [7:0] power_state;
    wire [7:0] unlock_key;
    wire [7:0] lane_select;
    wire [7:0] number_format;
    wire [7:0] ref_source;

    config_reg_bank u_regs (
        .core_clk(core_clk),
        .srst(srst),
        .wr_en(wr_en_r),
        .wr_addr(wr_addr_r),
        .wr_data(wr_data_r),
        .rd_addr(f_addr),
        .rd_data_r(rd_data),
        .power_state_r(power_state),
        .unlock_key_r(unlock_key),
        .lane_select_r(lane_select),
        .number_format_r(number_format),
        .ref_source_r(ref_source),
        .trim_a_low_r(ref_trim_a_low),
        .trim_a_high_r(ref_trim_a_high),
        .trim_b_low_r(ref_trim_b_low),
        .trim_b_high_r(ref_trim_b_high),
        .input_setup_r(input_setup)
    );

    // Field outputs, each a bank flip-flop
    assign converters_standby = power_state[`BIT_STANDBY];
    assign full_powerdown_enable = power_state[`BIT_FULL_PD];
    assign output_lane_mode_bit = lane_select[`BIT_LANE_MODE];
    assign twos_complement_fmt = number_format[`BIT_FORMAT];
    assign internal_ref_sel = ref_source[`BIT_INT_REF];

    // Power-state writes allowed only when unlocked
    wire unlock_code_field_ok = (unlock_key[`KEY_MSB:0] == `UNLOCK_VALUE);
    wire locked_target = (f_addr == `OFS_POWER_STATE) && !unlock_code_field_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Decoder state machine, runs after select rise
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg read_pend_r; // Read value waits for next frame
    reg [7:0] read_hold_r; // Value to shift out

    // Next state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                // Only complete frames go on
                if (cs_rise && frame_full) begin
                    state_nxt = ST_FETCH;
                end
            end
            ST_FETCH: begin
                // Bank read data valid next cycle
                state_nxt = ST_APPLY;
            end
            ST_APPLY: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // State, write strobe and read capture
    always @(posedge core_clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            wr_en_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
            read_pend_r <= 1'b0;
            read_hold_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            wr_en_r <= 1'b0;
            if (cs_fall) begin
                // Pending read is consumed by this frame
                read_pend_r <= 1'b0;
            end
            if (state_r == ST_APPLY) begin
                if (is_modify(f_cmd) && !locked_target) begin
                    wr_en_r <= 1'b1;
                    wr_addr_r <= f_addr;
                    wr_data_r <= apply_cmd(f_cmd, rd_data, f_data);
                end else if (f_cmd == `READ_CMD) begin
                    read_pend_r <= 1'b1;
                    read_hold_r <= rd_data;
                end
                // Idle and undefined codes do nothing
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion results sampled at frame end
    reg [15:0] conv_a_hold_r;
    reg [15:0] conv_b_hold_r;

    // Sample results when select rises
    always @(posedge core_clk) begin
        if (srst) begin
            conv_a_hold_r <= 16'h0000;
            conv_b_hold_r <= 16'h0000;
        end else if (cs_rise) begin
            conv_a_hold_r <= conv_a_data;
            conv_b_hold_r <= conv_b_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output shifters, change on serial clock falling edges
    reg [SHIFT_W-1:0] out_a_r; // Lane A bits, MSB first
    reg [SHIFT_W-1:0] out_b_r; // Lane B bits, MSB first
    wire [SHIFT_W-1:0] out_a_nxt = out_a_r << 1;
    wire [SHIFT_W-1:0] out_b_nxt = out_b_r << 1;

    // Load at frame start, shift thereafter
    always @(posedge core_clk) begin
        if (srst) begin
            out_a_r <= {SHIFT_W{1'b0}};
            out_b_r <= {SHIFT_W{1'b0}};
        end else if (cs_fall) begin
            if (read_pend_r) begin
                // Register value leads lane A
                out_a_r <= {read_hold_r, 24'h000000};
                out_b_r <= {SHIFT_W{1'b0}};
            end else if (output_lane_mode_bit) begin
                // Both results in turn on lane A
                out_a_r <= {conv_a_hold_r, conv_b_hold_r};
                out_b_r <= {SHIFT_W{1'b0}};
            end else begin
                // One result per lane
                out_a_r <= {conv_a_hold_r, 16'h0000};
                out_b_r <= {conv_b_hold_r, 16'h0000};
            end
        end else if (frame_on && sclk_fall) begin
            out_a_r <= out_a_nxt;
            out_b_r <= out_b_nxt;
        end
    end

    // Pin drivers: float outside frames
    always @(posedge core_clk) begin
        if (srst) begin
            serial_out_lane_a_r <= 1'b0;
            serial_out_lane_a_oe_r <= 1'b0;
            serial_out_lane_b_r <= 1'b0;
            serial_out_lane_b_oe_r <= 1'b0;
        end else begin
            serial_out_lane_a_r <= frame_on & out_a_r[SHIFT_W-1];
            serial_out_lane_a_oe_r <= frame_on;
            serial_out_lane_b_r <= frame_on & out_b_r[SHIFT_W-1];
            serial_out_lane_b_oe_r <= frame_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-up settling after leaving low-power states
    reg full_pd_d_r; // Previous full power-down bit
    reg stby_d_r; // Previous standby bit
    reg [CNT_W-1:0] settle_cnt_r;
    wire full_pd_exit = full_pd_d_r & ~full_powerdown_enable;
    wire stby_exit = stby_d_r & ~converters_standby;

    // Count settling time, length by reference source after full power-down
    always @(posedge core_clk) begin
        if (srst) begin
            full_pd_d_r <= 1'b0;
            stby_d_r <= 1'b0;
            settle_cnt_r <= {CNT_W{1'b0}};
            power_settled_r <= 1'b0;
        end else begin
            full_pd_d_r <= full_powerdown_enable;
            stby_d_r <= converters_standby;
            if (full_pd_exit) begin
                if (internal_ref_sel) begin
                    settle_cnt_r <= WAKE_INT_CYC[CNT_W-1:0];
                end else begin
                    settle_cnt_r <= WAKE_EXT_CYC[CNT_W-1:0];
                end
            end else if (stby_exit) begin
                settle_cnt_r <= WAKE_STBY_CYC[CNT_W-1:0];
            end else if (settle_cnt_r != {CNT_W{1'b0}}) begin
                settle_cnt_r <= settle_cnt_r - 1'b1;
            end
            // Ready when awake and no countdown runs
            power_settled_r <= ~full_powerdown_enable & ~converters_standby &
                ~full_pd_exit & ~stby_exit & (settle_cnt_r == {CNT_W{1'b0}});
        end
    end

endmodule // serial_command_port

//--- testbench/serial_port_chk.sv
// Concurrent checks on the pins of the serial command port
`timescale 1ns/10ps
module serial_port_chk (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Serial pins
    input wire cs_n,
    input wire serial_out_lane_a_r,
    input wire serial_out_lane_a_oe_r,
    input wire serial_out_lane_b_r,
    input wire serial_out_lane_b_oe_r,
    // Power and configuration
    input wire converters_standby,
    input wire full_powerdown_enable,
    input wire power_settled_r,
    input wire output_lane_mode_bit,
    input wire internal_ref_sel,
    input wire [7:0] ref_trim_a_low,
    input wire [7:0] ref_trim_a_high,
    input wire [7:0] input_setup
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////
    // Frame edges and power-down exit
    sequence frame_open; $fell(cs_n); endsequence
    sequence frame_close; $rose(cs_n); endsequence
    sequence pd_exit; $fell(full_powerdown_enable) && !converters_standby; endsequence
    ////////////////////////////////////////////////////////////////////////////
    lane_open_a: assert property (frame_open |-> ##[1:5] serial_out_lane_a_oe_r)
        else $error("lane A not enabled after frame start");
    lane_close_a: assert property (frame_close |-> ##[1:5] !serial_out_lane_a_oe_r)
        else $error("lane A still enabled after frame end");
    idle_lanes_a: assert property (!serial_out_lane_a_oe_r && !serial_out_lane_b_oe_r
        |-> !serial_out_lane_a_r && !serial_out_lane_b_r)
        else $error("lane level while not driven");
    single_lane_a: assert property (output_lane_mode_bit && !cs_n |-> !serial_out_lane_b_r)
        else $error("lane B active in single lane mode");
    trim_at_select_a: assert property ($changed(ref_trim_a_low) |-> cs_n && $past(cs_n))
        else $error("register changed inside a frame");
    power_at_select_a: assert property (
        $changed({converters_standby, full_powerdown_enable}) |-> cs_n)
        else $error("power state changed inside a frame");
    reserved_bits_a: assert property (input_setup[7:2] == 6'h00 && ref_trim_a_high[7:1] == 7'h00)
        else $error("reserved bit set");
    low_power_a: assert property (converters_standby || full_powerdown_enable
        |-> ##1 !power_settled_r)
        else $error("settled while powered down");
    wake_hold_a: assert property (pd_exit ##0 internal_ref_sel |-> !power_settled_r [*8])
        else $error("settled too early after power-down");
    wake_bound_a: assert property (pd_exit |-> ##[1:100] power_settled_r)
        else $error("never settled after power-down");
endmodule // serial_port_chk

bind serial_command_port serial_port_chk serial_port_chk_i (.core_clk(core_clk), .srst(srst),
    .cs_n(cs_n), .serial_out_lane_a_r(serial_out_lane_a_r),
    .serial_out_lane_a_oe_r(serial_out_lane_a_oe_r), .serial_out_lane_b_r(serial_out_lane_b_r),
    .serial_out_lane_b_oe_r(serial_out_lane_b_oe_r), .converters_standby(converters_standby),
    .full_powerdown_enable(full_powerdown_enable), .power_settled_r(power_settled_r),
    .output_lane_mode_bit(output_lane_mode_bit), .internal_ref_sel(internal_ref_sel),
    .ref_trim_a_low(ref_trim_a_low), .ref_trim_a_high(ref_trim_a_high),
    .input_setup(input_setup));

//--- testbench/host_link_model.sv
// Host controller model driving frames and collecting both lanes
`timescale 1ns/10ps
module host_link_model (
    // Core clock paces the host
    input wire core_clk,
    // Pins toward the port
    output reg cs_n,
    output reg sclk,
    output reg sdi,
    // Returned lanes
    input wire lane_a,
    input wire lane_a_oe,
    input wire lane_b,
    input wire lane_b_oe
);
    reg [31:0] rx_a; // Bits seen on lane A, last in at bit 0
    reg [31:0] rx_b; // Bits seen on lane B
    // Idle: deselected, clock high
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        sdi = 1'b0;
        rx_a = 32'h0;
        rx_b = 32'h0;
    end
    // Wait n core cycles, moving only on falling edges
    task tick(input integer n);
        repeat (n) @(negedge core_clk);
    endtask
    // One frame of n bits, MSB first, 800 ns clock period
    task frame(input [31:0] word, input integer n);
        integer i;
        begin
            tick(1);
            cs_n = 1'b0;
            for (i = n - 1; i >= 0; i = i - 1) begin
                tick(4);
                // Undriven lane reads as unknown, never as a bit
                rx_a = {rx_a[30:0], lane_a_oe ? lane_a : 1'bx};
                rx_b = {rx_b[30:0], lane_b_oe ? lane_b : 1'bx};
                sclk = 1'b0;
                sdi = word[i];
                tick(4);
                sclk = 1'b1;
            end
            tick(4);
            cs_n = 1'b1;
            // Released data line must not keep the last bit
            sdi = ~sdi;
            // Deselect time above the eight cycle minimum
            tick(12);
        end
    endtask
endmodule // host_link_model

//--- testbench/serial_command_port_bench.sv
// Self-checking bench of the serial command port
`timescale 1ns/10ps
`include "serial_port_defs.vh"
module serial_command_port_bench;
    reg core_clk, srst;
    reg [15:0] conv_a_data, conv_b_data;
    wire cs_n, sclk, sdi, la, la_oe, lb, lb_oe, stby, fpd, settled, mode, fmt, iref;
    wire [7:0] tal, tah, tbl, tbh, isu;
    integer err_count, checks, r, wake_cnt;
    reg [35:0] rows [0:15]; // Command, read offset, expected readback
    ////////////////////////////////////////////////////////////////////////////
    serial_command_port #(.WAKE_EXT_CYC(20), .WAKE_INT_CYC(60), .WAKE_STBY_CYC(5))
        serial_command_port_i (.core_clk(core_clk), .srst(srst), .cs_n(cs_n), .sclk(sclk),
        .sdi(sdi), .serial_out_lane_a_r(la), .serial_out_lane_a_oe_r(la_oe),
        .serial_out_lane_b_r(lb), .serial_out_lane_b_oe_r(lb_oe), .conv_a_data(conv_a_data),
        .conv_b_data(conv_b_data), .converters_standby(stby), .full_powerdown_enable(fpd),
        .power_settled_r(settled), .output_lane_mode_bit(mode), .twos_complement_fmt(fmt),
        .internal_ref_sel(iref), .ref_trim_a_low(tal), .ref_trim_a_high(tah),
        .ref_trim_b_low(tbl), .ref_trim_b_high(tbh), .input_setup(isu));
    host_link_model host_link_model_i (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk),
        .sdi(sdi), .lane_a(la), .lane_a_oe(la_oe), .lane_b(lb), .lane_b_oe(lb_oe));
    ////////////////////////////////////////////////////////////////////////////
    // 100 ns core clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Cycles spent waking after power-down ends
    always @(posedge core_clk) begin
        if (srst || fpd) wake_cnt <= 0;
        else if (!settled) wake_cnt <= wake_cnt + 1;
    end
    // Compare and count
    task check(input [31:0] seen, input [31:0] exp, input [8*8-1:0] what);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("wrong value %0s: expected %h, seen %h", what, exp, seen);
            end
        end
    endtask
    task send(input [31:0] w, input integer n);
        host_link_model_i.frame(w, n);
    endtask
    task stop_test;
        begin
            $display("checks %0d, mismatches %0d", checks, err_count);
            if (err_count == 0 && checks > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        err_count = 0;
        checks = 0;
        srst = 1'b1;
        conv_a_data = 16'hC3A5;
        conv_b_data = 16'h5A0F;
        rows[0] = 36'h124A5_24_A5;
        rows[1] = 36'h3240A_24_AF;
        rows[2] = 36'h42421_24_8E;
        rows[3] = 36'h128FF_28_03;
        rows[4] = 36'h52400_24_8E;
        rows[5] = 36'hF24FF_24_8E;
        rows[6] = 36'h00000_24_8E;
        rows[7] = 36'h10406_04_00;
        rows[8] = 36'h30406_04_00;
        rows[9] = 36'h10509_05_09;
        rows[10] = 36'h10D01_0D_01;
        rows[11] = 36'h11101_11_01;
        rows[12] = 36'h12001_20_01;
        rows[13] = 36'h125FF_25_01;
        rows[14] = 36'h1263C_26_3C;
        rows[15] = 36'h00000_30_00;
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        repeat (2) @(negedge core_clk);
        // Reset state of every register output
        check({tal, tah, tbl, tbh}, 32'h0, "reset");
        check({stby, fpd, mode, fmt, iref, isu, settled}, 14'h0001, "reset2");
        $display("test reset done");
        // Read request, then the next row's command while the value comes back
        send(rows[0][35:16], 20);
        for (r = 0; r < 16; r = r + 1) begin
            send({4'h2, rows[r][15:8], 8'h00}, 20);
            send(r < 15 ? rows[r + 1][35:16] : 20'h0, 20);
            check(host_link_model_i.rx_a[19:12], rows[r][7:0], "readback");
        end
        check({fmt, iref, mode, tah, tbh}, 19'h70100, "config");
        $display("test table done");
        // Short frame dropped, long frame keeps its last bits
        send(32'h126FF, 19);
        check(tbl, 8'h3C, "short");
        send({4'hF, 20'h1265A}, 24);
        check(tbl, 8'h5A, "long");
        $display("test framing done");
        // Power states behind the key, internal reference wake
        send(20'h10402, 20);
        check({stby, fpd}, 2'b01, "pd on");
        send(20'h30404, 20);
        check({stby, fpd, settled}, 3'b110, "standby");
        send(20'h40404, 20);
        check({stby, fpd}, 2'b01, "stby off");
        send(20'h40402, 20);
        for (r = 0; r < 200 && settled !== 1'b1; r = r + 1) @(negedge core_clk);
        if (r == 200) begin
            err_count = err_count + 1;
            stop_test;
        end
        check(wake_cnt >= 58 && wake_cnt <= 62, 1'b1, "wake");
        $display("test power done");
        // Single lane then dual lane conversion readout
        send(20'h0, 20);
        send(20'h0, 32);
        check(host_link_model_i.rx_a, 32'hC3A55A0F, "single a");
        check(host_link_model_i.rx_b, 32'h0, "single b");
        send(20'h10D00, 20);
        send(20'h0, 20);
        send(20'h0, 16);
        check(host_link_model_i.rx_a[15:0], 16'hC3A5, "dual a");
        check(host_link_model_i.rx_b[15:0], 16'h5A0F, "dual b");
        $display("test lanes done");
        // Reset in mid-run clears the bank and the lanes again
        srst = 1'b1;
        repeat (2) @(negedge core_clk);
        srst = 1'b0;
        repeat (2) @(negedge core_clk);
        check({fmt, iref, tal, tah, tbl, la_oe, settled}, 28'h0000001, "rst mid");
        $display("test mid reset done");
        stop_test;
    end
endmodule // serial_command_port_bench
